// [core/rds_pkg.sv]
// Purpose: shared constants and types of the random delay switch
// Assumes: 125 MHz system clock, one common timebase for both delays
// Notes:   delays are counted in whole timebase ticks
package rds_pkg;

  // clock and timebase
  localparam int unsigned CLK_FREQ_HZ    = 125_000_000;
  localparam int unsigned TIMEBASE_MS    = 10;
  localparam int unsigned TICK_CYCLES    = CLK_FREQ_HZ / 1000 * TIMEBASE_MS;

  // widths
  localparam int unsigned DELAY_W        = 16;
  localparam int unsigned TICK_W         = 24;
  localparam int unsigned PROD_W         = 2 * DELAY_W + 1;

  // pseudo-random source
  localparam logic [DELAY_W-1:0] LFSR_SEED = 16'hace1;
  localparam logic [DELAY_W-1:0] LFSR_TAPS = 16'hb400;

  // reset values and unit count steps
  localparam logic [DELAY_W-1:0] DELAY_ZERO = 16'h0000;
  localparam logic [TICK_W-1:0]  TICK_ZERO  = 24'h000000;
  localparam logic [TICK_W-1:0]  TICK_ONE   = 24'h000001;
  localparam logic [DELAY_W-1:0] DELAY_ONE  = 16'h0001;

  typedef enum logic [1:0] {
    RDS_IDLE     = 2'b00,
    RDS_ON_WAIT  = 2'b01,
    RDS_OFF_WAIT = 2'b10
  } rds_mode_t;

  // live delay limits from the providing blocks
  typedef struct packed {
    logic [DELAY_W-1:0] max_on_delay;
    logic [DELAY_W-1:0] max_off_delay;
  } rds_limits_t;

  // whole state of the switch
  typedef struct packed {
    rds_mode_t          mode;
    logic               enable_prev;
    logic [DELAY_W-1:0] lfsr;
    logic [DELAY_W-1:0] target;
    logic [DELAY_W-1:0] elapsed;
    logic [TICK_W-1:0]  tick_cnt;
    logic               switched;
    logic               busy;
  } rds_state_t;

endpackage

// [core/rds_top.sv]
// Purpose: switched output following an enable with random on/off delays
// Assumes: inputs synchronous to i_clk_sys; limits are live tick counts
// Notes:   reset stands for loss of supply and clears all timing
//          an edge seen while a delay runs restarts timing from zero
`timescale 1ns/1ps

// How it works
// [R01] enable rising edge starts on-delay drawn from zero to max on-delay
// [R02] output goes high at on-delay expiry if enable stayed high
// [R03] enable low during on-delay cancels it, output unchanged
// [R04] enable falling edge starts off-delay drawn from zero to max off-delay
// [R05] output goes low at off-delay expiry if enable stayed low
// [R06] enable high during off-delay cancels it, output unchanged
// [R07] power loss (reset) clears elapsed time and any running delay
// [R08] both maxima are live values supplied by other function blocks
// [R09] delays are whole ticks from a per-clock LFSR, zero to max inclusive
module rds_top #(
  parameter int unsigned TICK_CYCLES = rds_pkg::TICK_CYCLES
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_enable,
  input  wire rds_pkg::rds_limits_t        i_limits,
  output logic                             o_switch,
  output logic                             o_delay_busy,
  output logic [rds_pkg::DELAY_W-1:0]      o_elapsed
);

  // reset release chain
  logic                 rst_meta_reg;
  logic                 rst_sync_reg;

  // whole state of the switch and its next value
  rds_pkg::rds_state_t  state_reg;
  rds_pkg::rds_state_t  state_next;

  // decoded events of the current cycle
  logic                 rise;
  logic                 fall;
  logic                 tick;
  logic                 waiting;
  logic                 expired;

  // next LFSR word and the two scaled random delays
  logic [rds_pkg::DELAY_W-1:0] lfsr_step;
  logic [rds_pkg::DELAY_W-1:0] draw_on;
  logic [rds_pkg::DELAY_W-1:0] draw_off;

  localparam logic [rds_pkg::TICK_W-1:0] TICK_LAST =
    rds_pkg::TICK_W'(TICK_CYCLES - 1);

  // scale the random word into 0..max inclusive, one scaler per direction
  rds_scale #(
    .W       (rds_pkg::DELAY_W)
  ) u_rds_scale_on (
    .i_rnd   (state_reg.lfsr),          // R09
    .i_max   (i_limits.max_on_delay),   // R08
    .o_value (draw_on)
  );

  // the off-delay uses the same word; only one edge is taken per cycle
  rds_scale #(
    .W       (rds_pkg::DELAY_W)
  ) u_rds_scale_off (
    .i_rnd   (state_reg.lfsr),          // R09
    .i_max   (i_limits.max_off_delay),  // R08
    .o_value (draw_off)
  );

  // reset release through two flops
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // edge detection and timebase tick
  assign rise    = i_enable & ~state_reg.enable_prev;
  assign fall    = ~i_enable & state_reg.enable_prev;
  assign tick    = (state_reg.tick_cnt == TICK_LAST);

  // a delay runs in either wait mode and ends once its ticks are counted
  assign waiting = (state_reg.mode != rds_pkg::RDS_IDLE);
  assign expired = waiting && (state_reg.elapsed >= state_reg.target);

  // pseudo-random word steps every clock, edge or not
  rds_lfsr #(
    .W      (rds_pkg::DELAY_W),
    .TAPS   (rds_pkg::LFSR_TAPS)
  ) u_rds_lfsr (
    .i_word (state_reg.lfsr),
    .o_next (lfsr_step)    // R09
  );

  // next state of the switch
  always_comb begin
    // enable history, LFSR and tick divider run every cycle
    state_next             = state_reg;
    state_next.enable_prev = i_enable;
    state_next.lfsr        = lfsr_step;                        // R09
    state_next.tick_cnt    = tick ? rds_pkg::TICK_ZERO
                                  : state_reg.tick_cnt + rds_pkg::TICK_ONE;
    if (waiting && tick) begin
      state_next.elapsed = state_reg.elapsed + rds_pkg::DELAY_ONE;
    end
    if (rise) begin
      // a new edge cancels whatever delay was running
      state_next.mode     = rds_pkg::RDS_ON_WAIT;               // R01 R06
      state_next.target   = draw_on;                            // R01 R08 R09
      state_next.elapsed  = rds_pkg::DELAY_ZERO;                // R06
      state_next.tick_cnt = rds_pkg::TICK_ZERO;
    end else if (fall) begin
      state_next.mode     = rds_pkg::RDS_OFF_WAIT;              // R04 R03
      state_next.target   = draw_off;                           // R04 R08 R09
      state_next.elapsed  = rds_pkg::DELAY_ZERO;                // R03
      state_next.tick_cnt = rds_pkg::TICK_ZERO;
    end else begin
      // no edge: finish the running delay once its time is up
      case (state_reg.mode)
        // on-delay ran out with enable still high
        rds_pkg::RDS_ON_WAIT: begin
          if (expired) begin
            state_next.switched = 1'b1;                         // R02
            state_next.mode     = rds_pkg::RDS_IDLE;
            state_next.elapsed  = rds_pkg::DELAY_ZERO;
          end
        end

        // off-delay ran out with enable still low
        rds_pkg::RDS_OFF_WAIT: begin
          if (expired) begin
            state_next.switched = 1'b0;                         // R05
            state_next.mode     = rds_pkg::RDS_IDLE;
            state_next.elapsed  = rds_pkg::DELAY_ZERO;
          end
        end

        // nothing runs, elapsed stays at zero
        rds_pkg::RDS_IDLE: begin
          state_next.elapsed = rds_pkg::DELAY_ZERO;
        end

        // unused code falls back to idle
        default: begin
          state_next.mode = rds_pkg::RDS_IDLE;
        end
      endcase
    end
    // busy flop mirrors the mode the switch is about to enter
    state_next.busy = (state_next.mode != rds_pkg::RDS_IDLE);
  end

  // state register, cleared on power loss
  always_ff @(posedge i_clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg.mode        <= rds_pkg::RDS_IDLE;               // R07
      state_reg.enable_prev <= 1'b0;
      state_reg.lfsr        <= rds_pkg::LFSR_SEED;
      state_reg.target      <= rds_pkg::DELAY_ZERO;
      state_reg.elapsed     <= rds_pkg::DELAY_ZERO;             // R07
      state_reg.tick_cnt    <= rds_pkg::TICK_ZERO;
      state_reg.switched    <= 1'b0;
      state_reg.busy        <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  assign o_switch     = state_reg.switched;
  assign o_delay_busy = state_reg.busy;
  assign o_elapsed    = state_reg.elapsed;

endmodule

// advances a Fibonacci shift register by one step
// the all-zero word is a lock-up state; the seed keeps clear of it
module rds_lfsr #(
  parameter int unsigned  W    = rds_pkg::DELAY_W,
  parameter logic [W-1:0] TAPS = rds_pkg::LFSR_TAPS
) (
  input  wire logic [W-1:0] i_word,
  output logic      [W-1:0] o_next
);

  logic feedback;

  // parity of the tapped bits feeds the low end
  assign feedback = ^(i_word & TAPS);
  assign o_next   = {i_word[W-2:0], feedback};

endmodule

// scales a random word into the range zero to max, both ends included
// the product keeps every bit so no draw can wrap past the maximum
module rds_scale #(
  parameter int unsigned W = rds_pkg::DELAY_W
) (
  input  wire logic [W-1:0] i_rnd,
  input  wire logic [W-1:0] i_max,
  output logic      [W-1:0] o_value
);

  localparam int unsigned PW = 2 * W + 1;

  logic [PW-1:0] span;
  logic [PW-1:0] prod;

  // span is max plus one so that max itself can be drawn
  assign span = PW'(i_max) + PW'(1'b1);

  // the top half of rnd times span lies in 0..max
  assign prod    = PW'(i_rnd) * span;
  assign o_value = prod[PW-2:W];

endmodule

// [verif/rds_checker.sv]
// Purpose: port checks of the random delay switch
// Assumes: one clock, async active-low reset
// Notes:   alive_reg hides edges until the reset sync settles
`timescale 1ns/1ps
module rds_checker (
  input wire logic                          i_clk_sys,
  input wire logic                          i_rst_n,
  input wire logic                          i_enable,
  input wire rds_pkg::rds_limits_t          i_limits,
  input wire logic                          o_switch,
  input wire logic                          o_delay_busy,
  input wire logic [rds_pkg::DELAY_W-1:0]   o_elapsed
);
  logic [1:0] alive_reg;
  // counts settle edges after reset
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) alive_reg <= 2'h0;
    else if (alive_reg != 2'h3) alive_reg <= alive_reg + 2'h1;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // taken edges with a zero limit and a steady next cycle
  sequence s_on0;
    alive_reg[1] && $rose(i_enable) && i_limits[31:16] == 16'h0 ##1 i_enable;
  endsequence
  sequence s_off0;
    alive_reg[1] && $fell(i_enable) && i_limits[15:0] == 16'h0 ##1 !i_enable;
  endsequence
  property p_on0; s_on0 |=> o_switch; endproperty
  property p_off0; s_off0 |=> !o_switch; endproperty
  property p_hold_on;
    $rose(o_switch) |-> $past(i_enable, 1) && $past(i_enable, 2);
  endproperty
  property p_hold_off;
    $fell(o_switch) |-> !$past(i_enable, 1) && !$past(i_enable, 2);
  endproperty
  property p_start;
    alive_reg[1] && $changed(i_enable) |=> o_delay_busy && o_elapsed == 16'h0;
  endproperty
  property p_keep;
    alive_reg[1] && $changed(i_enable) |=> $stable(o_switch);
  endproperty
  property p_cause; $changed(o_switch) |-> $past(o_delay_busy); endproperty
  property p_clear; alive_reg == 2'h0 |-> !o_switch && !o_delay_busy; endproperty
  a_on0: assert property (p_on0) else $error("late on");
  a_off0: assert property (p_off0) else $error("late off");
  a_hold_on: assert property (p_hold_on) else $error("bad on");
  a_hold_off: assert property (p_hold_off) else $error("bad off");
  a_start: assert property (p_start) else $error("no start");
  a_keep: assert property (p_keep) else $error("moved");
  a_cause: assert property (p_cause) else $error("idle move");
  a_clear: assert property (p_clear) else $error("not clear");
endmodule

// [verif/rds_partner.sv]
// Purpose: enable source and live limit providers
// Assumes: commands arrive at a rising edge
// Notes:   outputs move only at rising edges
`timescale 1ns/1ps
module rds_partner (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_level,
  input  wire rds_pkg::rds_limits_t i_set,
  output logic                      o_enable,
  output rds_pkg::rds_limits_t      o_limits
);
  // present level and live limits one edge later
  always_ff @(posedge i_clk_sys) begin
    o_enable <= i_level;
    o_limits <= i_set;
  end
endmodule

// [verif/rds_top_tb.sv]
// Purpose: scenario bench of the random delay switch
// Assumes: a tick of 4 clocks keeps runs short
// Notes:   expectations follow the limits set per scenario
`timescale 1ns/1ps
module rds_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic level = 1'b0;
  rds_pkg::rds_limits_t set = '0;
  logic en, sw, busy;
  rds_pkg::rds_limits_t lim;
  logic [15:0] el;
  int n_errors = 0;
  int n_compared = 0;
  int cnt;
  always #4 clk = ~clk;
  rds_partner u_rds_partner (.i_clk_sys(clk), .i_level(level), .i_set(set),
    .o_enable(en), .o_limits(lim));
  rds_top #(.TICK_CYCLES(4)) u_rds_top (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_enable(en), .i_limits(lim), .o_switch(sw), .o_delay_busy(busy),
    .o_elapsed(el));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic go(input logic lv, input logic [31:0] l, input int n);
    @(posedge clk);
    level <= lv;
    set <= l;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_fast();
    go(1'b1, 32'h0, 6);
    check(16'(sw), 16'h1);
    go(1'b0, 32'h0, 6);
    check(16'(sw), 16'h0);
  endtask
  task automatic t_on_cancel();
    go(1'b1, 32'hffff0000, 1);
    go(1'b0, 32'hffff0000, 40);
    check({15'h0, sw | busy}, 16'h0);
  endtask
  task automatic t_off_cancel();
    go(1'b1, 32'h0, 6);
    go(1'b0, 32'h0000ffff, 1);
    go(1'b1, 32'h0000ffff, 40);
    check(16'(sw), 16'h1);
  endtask
  task automatic t_bound();
    for (int k = 0; k < 4; k++) begin
      go(1'b0, 32'h0, 6);
      go(1'b1, 32'h00030000, 0);
      for (cnt = 0; cnt < 30 && sw !== 1'b1; cnt++) @(posedge clk) #1;
      check(16'(cnt >= 3 && cnt <= 15 && cnt % 4 == 3), 16'h1);
    end
  endtask
  task automatic t_reset();
    go(1'b0, 32'hffff0000, 10);
    go(1'b1, 32'hffff0000, 10);
    @(posedge clk);
    rst_n <= 1'b0;
    level <= 1'b0;
    #1;
    check({sw, busy, el[13:0]}, 16'h0);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // watchdog cuts a hang short
  initial begin
    #40000;
    n_errors++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_fast();
    t_on_cancel();
    t_off_cancel();
    t_bound();
    t_reset();
    repeat (4) @(posedge clk);
    t_fast();
    summarize();
  end
endmodule
bind rds_top rds_checker u_rds_checker (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_enable(i_enable), .i_limits(i_limits),
  .o_switch(o_switch), .o_delay_busy(o_delay_busy), .o_elapsed(o_elapsed));
